/* File: verilog/ssp_sync_proc.sv */
// sync source muxes, input channel select and vertical sync separator
// assumes a plain register port master on clk_sys and async sync pins
//
// Summary of operation
// - control bits steer hsync, hold and vsync muxes
// - input control bit picks analog channel 0/1
// - separator is 8-bit up/down counter at 5 MHz
// - separator sees polarity-normalised composite sync only
// - search: count up in pulse, down to zero
// - vsync present once count exceeds programmed threshold
// - then clear, count absence, end at threshold
// - on end clear counter, search again
`timescale 1ns/1ps
`default_nettype none
`include "ssp_map.svh"
module ssp_sync_proc #(
  parameter int SEP_DIV = `SSP_SEP_DIV
) (
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  input  wire logic [`SSP_ADDR_W-1:0] reg_addr,
  input  wire logic [`SSP_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output var  logic [`SSP_DATA_W-1:0] reg_rdata,
  input  wire logic                   hsync_in,
  input  wire logic                   green_embedded_sync,
  input  wire logic                   pll_hold_in,
  input  wire logic                   vsync_in,
  output var  logic                   hsync_out_ff,
  output var  logic                   pll_hold_out_ff,
  output var  logic                   vsync_out_ff,
  output var  logic                   chan1_sel_ff,
  output var  logic                   sep_vsync_ff
);
  import ssp_pkg::*;

  logic [`SSP_DATA_W-1:0] sync_ctl_ff;
  logic [`SSP_DATA_W-1:0] hold_thr_ff;
  logic [`SSP_DATA_W-1:0] input_ctl_ff;
  logic [`SSP_DATA_W-1:0] nxt_rdata;

  logic hsync_s;
  logic green_s;
  logic hold_s;
  logic vsync_s;
  logic sep_tick;

  logic              comp_sync;
  logic [7:0]        sep_cnt_ff;
  logic [7:0]        sep_thr;
  ssp_sep_state_type sep_state_ff;

  // pin synchronisers
  ssp_pin_sync u_sync_hsync (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .pin_in    (hsync_in),
    .level_out (hsync_s)
  );

  ssp_pin_sync u_sync_green (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .pin_in    (green_embedded_sync),
    .level_out (green_s)
  );

  ssp_pin_sync u_sync_hold (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .pin_in    (pll_hold_in),
    .level_out (hold_s)
  );

  ssp_pin_sync u_sync_vsync (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .pin_in    (vsync_in),
    .level_out (vsync_s)
  );

  // 5 MHz separator enable
  ssp_tick_div #(
    .DIV (SEP_DIV)
  ) u_sep_div (
    .clk_sys (clk_sys),
    .srst    (srst),
    .tick    (sep_tick)
  );

  // register writes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync_ctl_ff  <= `SSP_RST_SYNC_CTL;
      hold_thr_ff  <= `SSP_RST_HOLD_THR;
      input_ctl_ff <= `SSP_RST_INPUT_CTL;
    end else if (reg_wr) begin
      case (reg_addr)
        `SSP_OFS_SYNC_CTL: begin
          sync_ctl_ff <= reg_wdata;
        end
        `SSP_OFS_HOLD_THR: begin
          hold_thr_ff <= reg_wdata;
        end
        `SSP_OFS_INPUT_CTL: begin
          input_ctl_ff <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // register reads, unmapped offsets answer zero
  always_comb begin
    nxt_rdata = '0;
    case (reg_addr)
      `SSP_OFS_SYNC_CTL: begin
        nxt_rdata = sync_ctl_ff;
      end
      `SSP_OFS_HOLD_THR: begin
        nxt_rdata = hold_thr_ff;
      end
      `SSP_OFS_INPUT_CTL: begin
        nxt_rdata = input_ctl_ff;
      end
      `SSP_OFS_SEP_STATUS: begin
        nxt_rdata = {7'h00, sep_vsync_ff};
      end
      `SSP_OFS_SEP_COUNT: begin
        nxt_rdata = sep_cnt_ff;
      end
      default: begin
        nxt_rdata = '0;
      end
    endcase
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end else begin
      reg_rdata <= '0;
    end
  end

  // source muxes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hsync_out_ff    <= 1'b0;
      pll_hold_out_ff <= 1'b0;
      vsync_out_ff    <= 1'b0;
    end else begin
      hsync_out_ff    <= sync_ctl_ff[`SSP_BIT_HSYNC_SEL] ? green_s : hsync_s;
      pll_hold_out_ff <= hold_thr_ff[`SSP_BIT_HOLD_SEL] ? vsync_s : hold_s;
      vsync_out_ff    <= sync_ctl_ff[`SSP_BIT_VSYNC_SEL] ? sep_vsync_ff : vsync_s;
    end
  end

  // analog switch select; the analog path itself sits outside
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      chan1_sel_ff <= 1'b0;
    end else begin
      chan1_sel_ff <= input_ctl_ff[`SSP_BIT_CHAN_SEL];
    end
  end

  // polarity is fixed upstream, so high always means pulse active
  assign comp_sync = sync_ctl_ff[`SSP_BIT_HSYNC_SEL] ? green_s : hsync_s;

  // bit 5 of the shared register is the hold select, so the threshold
  // is the other seven bits; limits the threshold to 127
  assign sep_thr = {1'b0, hold_thr_ff[7:6], hold_thr_ff[4:0]};

  // separator counter and state
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sep_state_ff <= SSP_SEARCH;
      sep_cnt_ff   <= 8'h00;
      sep_vsync_ff <= 1'b0;
    end else if (sep_tick) begin
      case (sep_state_ff)
        SSP_SEARCH: begin
          if (sep_cnt_ff > sep_thr) begin
            sep_state_ff <= SSP_PRESENT;
            sep_vsync_ff <= 1'b1;
            sep_cnt_ff   <= 8'h00;
          end else if (comp_sync) begin
            if (sep_cnt_ff != `SSP_CNT_MAX) begin
              sep_cnt_ff <= sep_cnt_ff + 8'h01;
            end
          end else if (sep_cnt_ff != 8'h00) begin
            sep_cnt_ff <= sep_cnt_ff - 8'h01;
          end
        end
        SSP_PRESENT: begin
          // short serration gaps add up but never reach the end alone
          if (sep_cnt_ff >= sep_thr) begin
            sep_state_ff <= SSP_SEARCH;
            sep_vsync_ff <= 1'b0;
            sep_cnt_ff   <= 8'h00;
          end else if (!comp_sync && sep_cnt_ff != `SSP_CNT_MAX) begin
            sep_cnt_ff <= sep_cnt_ff + 8'h01;
          end
        end
        default: begin
          sep_state_ff <= SSP_SEARCH;
          sep_cnt_ff   <= 8'h00;
          sep_vsync_ff <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: verilog/ssp_map.svh */
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the sync-processing design files
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH

`define SSP_ADDR_W          8
`define SSP_DATA_W          8

`define SSP_OFS_SYNC_CTL    8'h0e
`define SSP_OFS_HOLD_THR    8'h0f
`define SSP_OFS_INPUT_CTL   8'h15
`define SSP_OFS_SEP_STATUS  8'h1a
`define SSP_OFS_SEP_COUNT   8'h1b

`define SSP_BIT_VSYNC_SEL   0
`define SSP_BIT_HSYNC_SEL   3
`define SSP_BIT_HOLD_SEL    5
`define SSP_BIT_CHAN_SEL    3

`define SSP_RST_SYNC_CTL    8'h00
`define SSP_RST_HOLD_THR    8'h00
`define SSP_RST_INPUT_CTL   8'h00

`define SSP_CNT_MAX         8'hff
`define SSP_SYS_CLK_HZ      250000000
`define SSP_SEP_CLK_HZ      5000000
`define SSP_SEP_DIV         (`SSP_SYS_CLK_HZ / `SSP_SEP_CLK_HZ)

`endif

/* File: verilog/ssp_pkg.sv */
// types shared by the sync-processing design files
// assumes nothing beyond a SystemVerilog compiler
package ssp_pkg;

  typedef enum logic [1:0] {
    SSP_SEARCH  = 2'b00,
    SSP_PRESENT = 2'b01
  } ssp_sep_state_type;

endpackage

/* File: verilog/ssp_pin_sync.sv */
// three-flop input synchroniser with agreement filter
// assumes the input is asynchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module ssp_pin_sync (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic pin_in,
  output var  logic level_out
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  // first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      level_out <= 1'b0;
    end else if (s2_ff == s3_ff) begin
      level_out <= s3_ff;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/ssp_tick_div.sv */
// divider making a one-cycle enable pulse every DIV cycles
// assumes DIV is at least 1
`timescale 1ns/1ps
`default_nettype none
module ssp_tick_div #(
  parameter int DIV = 50
) (
  input  wire logic clk_sys,
  input  wire logic srst,
  output var  logic tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_ff;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_ff <= '0;
      tick   <= 1'b0;
    end else if (cnt_ff == LAST) begin
      cnt_ff <= '0;
      tick   <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
      tick   <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/ssp_sync_proc_checker.sv */
// port-level assertions for ssp_sync_proc
// assumes bind onto ssp_sync_proc with SEP_DIV of 2 or more
`timescale 1ns/1ps
`default_nettype none
module ssp_sync_proc_checker (
  input wire logic       clk_sys,
  input wire logic       srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       hsync_in,
  input wire logic       green_embedded_sync,
  input wire logic       pll_hold_in,
  input wire logic       vsync_in,
  input wire logic       hsync_out_ff,
  input wire logic       pll_hold_out_ff,
  input wire logic       vsync_out_ff,
  input wire logic       chan1_sel_ff,
  input wire logic       sep_vsync_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic [7:0] e_ff;
  logic       f5_ff;
  logic       c3_ff;
  // shadow select bits, seen only through writes
  always_ff @(posedge clk_sys) begin
    if (srst) {e_ff, f5_ff, c3_ff} <= 10'h000;
    else if (reg_wr) begin
      if (reg_addr == 8'h0e) e_ff <= reg_wdata;
      if (reg_addr == 8'h0f) f5_ff <= reg_wdata[5];
      if (reg_addr == 8'h15) c3_ff <= reg_wdata[3];
    end
  end
  // seven stable cycles cover the pin synchroniser latency
  property p_hs; ($stable({e_ff[3], hsync_in, green_embedded_sync}))[*7]
    |-> hsync_out_ff == (e_ff[3] ? green_embedded_sync : hsync_in); endproperty
  property p_hold; ($stable({f5_ff, pll_hold_in, vsync_in}))[*7]
    |-> pll_hold_out_ff == (f5_ff ? vsync_in : pll_hold_in); endproperty
  property p_vs; ($stable({e_ff[0], vsync_in, sep_vsync_ff}))[*7]
    |-> vsync_out_ff == (e_ff[0] ? sep_vsync_ff : vsync_in); endproperty
  property p_ch; $stable(c3_ff)[*3] |-> chan1_sel_ff == c3_ff; endproperty
  property p_rdz; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  property p_rd0e; $past(reg_rd && reg_addr == 8'h0e) |-> reg_rdata == $past(e_ff); endproperty
  property p_rd1a; $past(reg_rd && reg_addr == 8'h1a) |-> reg_rdata == {7'h00, $past(sep_vsync_ff)}; endproperty
  property p_rest; $fell(sep_vsync_ff) |=> !sep_vsync_ff[*3]; endproperty
  a_hs: assert property (p_hs) else $error("hsync mux mismatch");
  a_hold: assert property (p_hold) else $error("hold mux mismatch");
  a_vs: assert property (p_vs) else $error("vsync mux mismatch");
  a_ch: assert property (p_ch) else $error("channel select mismatch");
  a_rdz: assert property (p_rdz) else $error("read data not idle");
  a_rd0e: assert property (p_rd0e) else $error("sync control readback");
  a_rd1a: assert property (p_rd1a) else $error("status readback");
  a_rest: assert property (p_rest) else $error("search restart too early");
  c_det: cover property ($rose(sep_vsync_ff));
  c_end: cover property ($fell(sep_vsync_ff));
  c_b2b: cover property (reg_wr ##1 reg_rd);
endmodule
bind ssp_sync_proc ssp_sync_proc_checker chk (.*);
`default_nettype wire

/* File: testbench/ssp_sync_src.sv */
// composite sync source: line pulses, one broad pulse per frame
// assumes en changes just after a clk_sys edge
`timescale 1ns/1ps
`default_nettype none
module ssp_sync_src #(
  parameter int LINE  = 40,
  parameter int FRAME = 400
) (
  input  wire logic clk_sys,
  input  wire logic en,
  output var  logic comp
);
  int c;
  // idle low while off, so no stray pulses reach the separator
  always_ff @(posedge clk_sys) c <= en ? (c + 1) % FRAME : 0;
  // last line wholly active stands in for the vertical interval
  always_comb comp = en && (c % LINE < 4 || c >= FRAME - LINE);
endmodule
`default_nettype wire

/* File: testbench/ssp_sync_proc_test.sv */
// self-checking bench for ssp_sync_proc
// assumes design files, checker and ssp_sync_src compiled first
`timescale 1ns/1ps
`default_nettype none
module ssp_sync_proc_test;
  logic clk_sys = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, src_on = 1'b0;
  logic comp, hs_o, hold_o, vs_o, ch_o, sep_o;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [3:0] tp = 4'h0;
  // {e3,e0,f5,c3} {hs,sog,hold,vs} {hs_o,hold_o,vs_o,ch}
  logic [11:0] rows [4] = '{12'b0000_1010_1100, 12'b1011_1001_0111, 12'b1100_1001_0000, 12'b1010_0110_1000};
  int errors = 0, samples_checked = 0, n;
  wire [3:0] outs = {hs_o, hold_o, vs_o, ch_o};
  always #2 clk_sys = ~clk_sys;
  ssp_sync_src src (.clk_sys(clk_sys), .en(src_on), .comp(comp));
  ssp_sync_proc #(.SEP_DIV(2)) dut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hsync_in(src_on ? comp : tp[3]),
    .green_embedded_sync(tp[2]), .pll_hold_in(tp[1]), .vsync_in(tp[0]), .hsync_out_ff(hs_o),
    .pll_hold_out_ff(hold_o), .vsync_out_ff(vs_o), .chan1_sel_ff(ch_o), .sep_vsync_ff(sep_o));
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, e);
    @(posedge clk_sys);
  endtask
  // bounded wait for the vsync output level
  task automatic wt(logic lv, int lim, output int k);
    k = 0;
    do begin
      @(posedge clk_sys);
      #1 k++;
      if (k > lim) begin
        errors++;
        conclude();
      end
    end while (vs_o !== lv);
    @(posedge clk_sys);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    // threshold 31 keeps the separator quiet here
    foreach (rows[i]) begin
      // one idle edge between writes, strobe never dropped and raised at once
      wr(8'h0e, {4'h0, rows[i][11], 2'b00, rows[i][10]});
      @(posedge clk_sys);
      wr(8'h0f, {2'b00, rows[i][9], 5'h1f});
      @(posedge clk_sys);
      wr(8'h15, {4'h0, rows[i][8], 3'h0});
      tp <= rows[i][7:4];
      repeat (8) @(posedge clk_sys);
      #1 chk("mux", {4'h0, outs}, {4'h0, rows[i][3:0]});
      @(posedge clk_sys);
      rd(8'h0e, {4'h0, rows[i][11], 2'b00, rows[i][10]});
    end
    srst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    tp <= 4'h0;
    #1 chk("reset", {4'h0, outs}, 8'h00);
    @(posedge clk_sys);
    rd(8'h0f, 8'h00);
    wr(8'h1b, 8'hff);
    rd(8'h1b, 8'h00);
    rd(8'h33, 8'h00);
    wr(8'h0e, 8'h01);
    rd(8'h0e, 8'h01);
    wr(8'h0f, 8'h05);
    src_on <= 1'b1;
    wt(1'b1, 1000, n);
    chk("detect", {7'h00, n > 360 && n < 420}, 8'h01);
    chk("sep", {7'h00, sep_o}, 8'h01);
    rd(8'h1a, 8'h01);
    // pulse still active, cleared count must hold
    rd(8'h1b, 8'h00);
    wt(1'b0, 100, n);
    chk("end", {7'h00, n > 25 && n < 55}, 8'h01);
    chk("sep", {7'h00, sep_o}, 8'h00);
    rd(8'h1b, 8'h00);
    conclude();
  end
endmodule
`default_nettype wire
